// ### rsss_asserts.sv
// concurrent checks on the supervisor ports
`timescale 1ns/1ps
`default_nettype none
module rsss_asserts (
  input wire logic        core_clk_in,
  input wire logic        reset_in,
  input wire logic        watchdog_reset_in,
  input wire logic        power_fail_control_in,
  input wire logic        power_fail_action_select_in,
  input wire logic        power_fail_near_in,
  input wire logic        low_supply_detector_in,
  input wire logic [7:0]  vector_data_in,
  input wire logic        core_reset_out,
  input wire logic        core_freeze_out,
  input wire logic        vector_read_out,
  input wire logic [15:0] vector_addr_out,
  input wire logic        pc_load_out,
  input wire logic [15:0] pc_value_out,
  input wire logic [7:0]  ram_page_select_out,
  input wire logic        direct_page_flag_out,
  input wire logic        main_clock_select_out,
  input wire logic        booster_on_out,
  input wire logic        power_fail_detector_on_out,
  input wire logic        stop_release_enable_out,
  input wire logic        ports_force_input_out,
  input wire logic        ram_write_block_out,
  input wire logic        low_supply_mode_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  ////////////////////////////////////////////////////////////////
  wdog_reset_a: assert property (watchdog_reset_in[*4] |-> core_reset_out)
    else $error("watchdog request did not reset");
  vec_order_a: assert property (vector_read_out && vector_addr_out == 16'hfffe
    |=> vector_read_out && vector_addr_out == 16'hffff)
    else $error("vector bytes out of order");
  pc_load_a: assert property (vector_read_out && vector_addr_out == 16'hffff
    |=> pc_load_out && !core_reset_out)
    else $error("pc load not after high byte");
  pc_value_a: assert property (pc_load_out
    |-> pc_value_out == {$past(vector_data_in), $past(vector_data_in, 2)})
    else $error("pc value not from vector");
  reset_state_a: assert property (core_reset_out |-> ram_page_select_out == 8'h00
    && !direct_page_flag_out && main_clock_select_out && !booster_on_out
    && !power_fail_detector_on_out)
    else $error("reset state wrong");
  ram_guard_a: assert property (ram_write_block_out == core_reset_out)
    else $error("ram guard differs from core reset");
  pfd_off_a: assert property (!power_fail_control_in[*2] |=> !power_fail_detector_on_out)
    else $error("detector armed while disabled");
  pf_action_a: assert property (power_fail_detector_on_out ##0 power_fail_near_in[*8]
    |-> ##[1:4] (power_fail_action_select_in ? core_freeze_out : core_reset_out))
    else $error("power fail action missing");
  low_mode_a: assert property (low_supply_detector_in[*4] |-> low_supply_mode_out
    && ports_force_input_out && !stop_release_enable_out)
    else $error("low supply mode wrong");
  low_ram_a: assert property (low_supply_mode_out |-> ram_write_block_out)
    else $error("memory writable in low supply mode");
  cover property (pc_load_out);
  cover property (core_freeze_out);
  cover property (low_supply_mode_out);
endmodule : rsss_asserts
bind rsss_supervisor rsss_asserts u_chk (.core_clk_in, .reset_in, .watchdog_reset_in,
  .power_fail_control_in, .power_fail_action_select_in, .power_fail_near_in,
  .low_supply_detector_in, .vector_data_in, .core_reset_out, .core_freeze_out,
  .vector_read_out, .vector_addr_out, .pc_load_out, .pc_value_out, .ram_page_select_out,
  .direct_page_flag_out, .main_clock_select_out, .booster_on_out,
  .power_fail_detector_on_out, .stop_release_enable_out, .ports_force_input_out,
  .ram_write_block_out, .low_supply_mode_out);
`default_nettype wire

// ### rsss_if.sv
// qualified reset request from the pin qualifier to the sequencer
`timescale 1ns/1ps
`default_nettype none
interface rsss_if;
  logic ext_reset_req;
  modport qual (output ext_reset_req);
  modport seq  (input  ext_reset_req);
endinterface : rsss_if
`default_nettype wire

// ### rsss_params.svh
// constants for the reset and supply supervisor
`ifndef RSSS_PARAMS_SVH
`define RSSS_PARAMS_SVH
`define RSSS_CLK_HZ          50000000
`define RSSS_EXT_LOW_MIN     8
`define RSSS_STAB_TIME_US    65500
`define RSSS_STAB_REF_HZ     4000000
`define RSSS_STAB_CYC        (`RSSS_STAB_TIME_US * (`RSSS_CLK_HZ / 1000000))
`define RSSS_TAIL_CYC        7
`define RSSS_PF_TIME_NS      100
`define RSSS_PF_CYC          ((`RSSS_PF_TIME_NS * (`RSSS_CLK_HZ / 1000000) + 999) / 1000)
`define RSSS_VECTOR_LO       16'hfffe
`define RSSS_VECTOR_HI       16'hffff
`define RSSS_PAGE_RESET      8'h00
`define RSSS_PF_ACT_RESET    1'b0
`define RSSS_PF_ACT_FREEZE   1'b1
`endif

// ### rsss_partner.sv
// board reset circuit and vector memory beside the supervisor
`timescale 1ns/1ps
`default_nettype none
module rsss_partner #(
  parameter logic [7:0] VEC_LO = 8'h34,
  parameter logic [7:0] VEC_HI = 8'h12
) (
  input  wire logic        core_clk_in,
  input  wire logic        vector_read_in,
  input  wire logic [15:0] vector_addr_in,
  output var logic         reset_pin_n_out,
  output logic [7:0]       vector_data_out
);
  logic [7:0] pat = 8'h5a;
  initial reset_pin_n_out = 1'b1;
  // unread data changes every cycle
  always @(posedge core_clk_in) pat <= ~pat;
  assign vector_data_out = !vector_read_in ? pat
    : (vector_addr_in == 16'hfffe) ? VEC_LO : VEC_HI;
  task automatic press(input int n);
    @(negedge core_clk_in);
    reset_pin_n_out = 1'b0;
    repeat (n) @(negedge core_clk_in);
    reset_pin_n_out = 1'b1;
  endtask : press
endmodule : rsss_partner
`default_nettype wire

// ### rsss_pin_qual.sv
// synchronises the reset pin and qualifies a minimum low duration
`timescale 1ns/1ps
`default_nettype none
`include "rsss_params.svh"
module rsss_pin_qual
  import rsss_pkg::*;
#(
  parameter int LOW_MIN = `RSSS_EXT_LOW_MIN
) (
  input  wire logic core_clk_in,
  input  wire logic reset_in,
  input  wire logic reset_pin_n_in,
  rsss_if.qual      qual_if
);
  typedef struct packed {
    logic       sync1;
    logic       sync2;
    logic [7:0] low_cnt;
    logic       req;
  } rsss_qual_t;
  rsss_qual_t q_reg;
  rsss_qual_t q_next;

  always_comb begin
    q_next = q_reg;
    q_next.sync1 = reset_pin_n_in;
    q_next.sync2 = q_reg.sync1;
    if (q_reg.sync2) begin
      q_next.low_cnt = 8'h00;
      q_next.req     = 1'b0;
    end else if (q_reg.low_cnt < 8'(LOW_MIN - 1)) begin
      q_next.low_cnt = q_reg.low_cnt + 8'h01;
    end else begin
      q_next.req = 1'b1;
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      q_reg <= '{sync1: 1'b1, sync2: 1'b1, low_cnt: 8'h00, req: 1'b0};
    end else begin
      q_reg <= q_next;
    end
  end

  assign qual_if.ext_reset_req = q_reg.req;
endmodule : rsss_pin_qual
`default_nettype wire

// ### rsss_pkg.sv
// types for the reset and supply supervisor
package rsss_pkg;
  typedef enum logic [2:0] {
    RSSS_ST_RESET  = 3'b000,
    RSSS_ST_STAB   = 3'b001,
    RSSS_ST_TAIL   = 3'b010,
    RSSS_ST_VEC_LO = 3'b011,
    RSSS_ST_VEC_HI = 3'b100,
    RSSS_ST_RUN    = 3'b101,
    RSSS_ST_LOWV   = 3'b110
  } rsss_state_t;
endpackage : rsss_pkg

// ### rsss_supervisor.sv
// reset sources, start-up delay, vector fetch, power fail and low supply
// Function
// - Either the qualified reset pin or the watchdog request resets the internal state.
// - After release the block waits the stabilisation time and 7 more cycles before fetching.
// - The program counter is loaded from the vector at fffe and ffff and execution starts.
// - Reset clears page select and direct page flag, picks main clock, enables peripheral clock, disables power fail detector and booster.
// - Data RAM contents are never touched by reset.
// - A software control bit enables or disables the power fail detector.
// - A supply near the fail threshold for 100 ns resets or freezes the core per the action select bit.
// - A low supply enters low supply mode, in which stop release is disabled.
// - In low supply mode all port pins become inputs and data memory is kept.
// - A reset after supply restore leaves low supply mode into the normal reset sequence.
`timescale 1ns/1ps
`default_nettype none
`include "rsss_params.svh"
module rsss_supervisor
  import rsss_pkg::*;
#(
  parameter int STAB_CYC = `RSSS_STAB_CYC,
  parameter int TAIL_CYC = `RSSS_TAIL_CYC,
  parameter int PF_CYC   = `RSSS_PF_CYC
) (
  input  wire logic        core_clk_in,
  input  wire logic        reset_in,
  input  wire logic        reset_pin_n_in,
  input  wire logic        watchdog_reset_in,
  input  wire logic        power_fail_control_in,
  input  wire logic        power_fail_action_select_in,
  input  wire logic        power_fail_near_in,
  input  wire logic        low_supply_detector_in,
  input  wire logic [7:0]  vector_data_in,
  output logic             core_reset_out,
  output logic             core_freeze_out,
  output logic             vector_read_out,
  output logic [15:0]      vector_addr_out,
  output logic             pc_load_out,
  output logic [15:0]      pc_value_out,
  output logic [7:0]       ram_page_select_out,
  output logic             direct_page_flag_out,
  output logic             main_clock_select_out,
  output logic             peripheral_clock_on_out,
  output logic             power_fail_detector_on_out,
  output logic             booster_on_out,
  output logic             stop_release_enable_out,
  output logic             ports_force_input_out,
  output logic             ram_write_block_out,
  output logic             low_supply_mode_out
);
  typedef struct packed {
    rsss_state_t state;
    logic [31:0] cnt;
    logic [7:0]  pf_cnt;
    logic        pf_en;
    logic [7:0]  vec_lo;
    logic        wd_s1;
    logic        wd_s2;
    logic        pfn_s1;
    logic        pfn_s2;
    logic        lv_s1;
    logic        lv_s2;
    logic        core_reset;
    logic        freeze;
    logic        vec_rd;
    logic [15:0] vec_addr;
    logic        pc_load;
    logic [15:0] pc_val;
    logic        pfd_on;
    logic        lowv;
    logic [7:0]  page;
    logic        dp_flag;
    logic        main_clk;
    logic        peri_clk;
    logic        booster;
    logic        stop_rel;
  } rsss_sup_t;

  rsss_sup_t s_reg;
  rsss_sup_t s_next;
  rsss_if    req_if ();

  rsss_pin_qual #(
    .LOW_MIN (`RSSS_EXT_LOW_MIN)
  ) u_qual (
    .core_clk_in    (core_clk_in),
    .reset_in       (reset_in),
    .reset_pin_n_in (reset_pin_n_in),
    .qual_if        (req_if.qual)
  );

  ////////////////////////////////////////////////////////////////////////////
  logic any_reset;
  logic pf_trip;

  always_comb begin
    s_next = s_reg;
    s_next.wd_s1  = watchdog_reset_in;
    s_next.wd_s2  = s_reg.wd_s1;
    s_next.pfn_s1 = power_fail_near_in;
    s_next.pfn_s2 = s_reg.pfn_s1;
    s_next.lv_s1  = low_supply_detector_in;
    s_next.lv_s2  = s_reg.lv_s1;
    s_next.pc_load = 1'b0;
    s_next.vec_rd  = 1'b0;
    s_next.pf_en   = power_fail_control_in;
    // power fail filter: threshold must hold PF_CYC + 1 cycles
    pf_trip = 1'b0;
    if (s_reg.pf_en && s_reg.pfd_on && s_reg.pfn_s2) begin
      if (s_reg.pf_cnt < 8'(PF_CYC)) begin
        s_next.pf_cnt = s_reg.pf_cnt + 8'h01;
      end else begin
        pf_trip = 1'b1;
      end
    end else begin
      s_next.pf_cnt = 8'h00;
    end
    s_next.freeze = pf_trip && (power_fail_action_select_in == `RSSS_PF_ACT_FREEZE);
    any_reset = req_if.ext_reset_req || s_reg.wd_s2 ||
                (pf_trip && (power_fail_action_select_in == `RSSS_PF_ACT_RESET));
    if (any_reset) begin
      s_next.state      = RSSS_ST_RESET;
      s_next.core_reset = 1'b1;
      s_next.cnt        = 32'h0;
      s_next.lowv       = 1'b0;
      s_next.pfd_on     = 1'b0;
      s_next.freeze     = 1'b0;
      s_next.pf_cnt     = 8'h00;
      // reset state of page, flag, clocks and booster
      s_next.page       = `RSSS_PAGE_RESET;
      s_next.dp_flag    = 1'b0;
      s_next.main_clk   = 1'b1;
      s_next.peri_clk   = 1'b1;
      s_next.booster    = 1'b0;
    end else if (s_reg.lv_s2 && s_reg.state != RSSS_ST_LOWV) begin
      s_next.state = RSSS_ST_LOWV;
      s_next.lowv  = 1'b1;
      // core and memory writes blocked from the first cycle of low supply
      s_next.core_reset = 1'b1;
      s_next.pfd_on     = 1'b0;
    end else begin
      case (s_reg.state)
        RSSS_ST_RESET: begin
          s_next.state = RSSS_ST_STAB;
          s_next.cnt   = 32'h0;
        end
        RSSS_ST_STAB: begin
          if (s_reg.cnt >= 32'(STAB_CYC - 1)) begin
            s_next.state = RSSS_ST_TAIL;
            s_next.cnt   = 32'h0;
          end else begin
            s_next.cnt = s_reg.cnt + 32'h1;
          end
        end
        RSSS_ST_TAIL: begin
          if (s_reg.cnt >= 32'(TAIL_CYC - 1)) begin
            s_next.state    = RSSS_ST_VEC_LO;
            s_next.vec_rd   = 1'b1;
            s_next.vec_addr = `RSSS_VECTOR_LO;
          end else begin
            s_next.cnt = s_reg.cnt + 32'h1;
          end
        end
        RSSS_ST_VEC_LO: begin
          s_next.vec_lo   = vector_data_in;
          s_next.vec_rd   = 1'b1;
          s_next.vec_addr = `RSSS_VECTOR_HI;
          s_next.state    = RSSS_ST_VEC_HI;
        end
        RSSS_ST_VEC_HI: begin
          s_next.pc_val     = {vector_data_in, s_reg.vec_lo};
          s_next.pc_load    = 1'b1;
          s_next.core_reset = 1'b0;
          s_next.state      = RSSS_ST_RUN;
        end
        RSSS_ST_RUN: begin
          // the detector is armed by software once running
          s_next.pfd_on = s_reg.pf_en;
        end
        RSSS_ST_LOWV: begin
          // held until a reset arrives; memory untouched
          s_next.core_reset = 1'b1;
        end
        default: begin
          s_next.state = RSSS_ST_RESET;
        end
      endcase
    end
    s_next.stop_rel = ~s_next.lowv;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      s_reg <= '{state: RSSS_ST_RESET, cnt: 32'h0, pf_cnt: 8'h00, pf_en: 1'b0,
                 vec_lo: 8'h00, wd_s1: 1'b0, wd_s2: 1'b0, pfn_s1: 1'b0,
                 pfn_s2: 1'b0, lv_s1: 1'b0, lv_s2: 1'b0, core_reset: 1'b1,
                 freeze: 1'b0, vec_rd: 1'b0, vec_addr: 16'h0000, pc_load: 1'b0,
                 pc_val: 16'h0000, pfd_on: 1'b0, lowv: 1'b0,
                 page: `RSSS_PAGE_RESET, dp_flag: 1'b0, main_clk: 1'b1,
                 peri_clk: 1'b1, booster: 1'b0, stop_rel: 1'b1};
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign core_reset_out             = s_reg.core_reset;
  assign core_freeze_out            = s_reg.freeze;
  assign vector_read_out            = s_reg.vec_rd;
  assign vector_addr_out            = s_reg.vec_addr;
  assign pc_load_out                = s_reg.pc_load;
  assign pc_value_out               = s_reg.pc_val;
  assign ram_page_select_out        = s_reg.page;
  assign direct_page_flag_out       = s_reg.dp_flag;
  assign main_clock_select_out      = s_reg.main_clk;
  assign peripheral_clock_on_out    = s_reg.peri_clk;
  assign power_fail_detector_on_out = s_reg.pfd_on;
  assign booster_on_out             = s_reg.booster;
  assign stop_release_enable_out    = s_reg.stop_rel;
  assign ports_force_input_out      = s_reg.lowv;
  assign ram_write_block_out        = s_reg.core_reset;
  assign low_supply_mode_out        = s_reg.lowv;
endmodule : rsss_supervisor
`default_nettype wire

// ### rsss_supervisor_bench.sv
// self-checking bench for the reset and supply supervisor
`timescale 1ns/1ps
`default_nettype none
module rsss_supervisor_bench;
  localparam int STAB = 20;
  logic clk = 1'b0, rst = 1'b1, wd = 1'b0, pfc = 1'b0, pfa = 1'b0, pfn = 1'b0, lsd = 1'b0;
  logic cr, fz, vr, pl, dp, mc, pc, pfo, bo, sre, pfi, rwb, lsm, pin_n;
  logic [15:0] va, pv;
  logic [7:0]  rp, vd;
  int fails = 0, n_compared = 0, cyc = 0, boot_len = 0;
  always #10 clk = ~clk;
  // cycles the core has been held in reset, up to and including its release edge
  always @(posedge clk) boot_len <= (cr === 1'b1) ? boot_len + 1 : 0;
  rsss_supervisor #(.STAB_CYC(STAB)) u_dut (.core_clk_in(clk),
    .reset_in(rst), .reset_pin_n_in(pin_n), .watchdog_reset_in(wd),
    .power_fail_control_in(pfc), .power_fail_action_select_in(pfa),
    .power_fail_near_in(pfn), .low_supply_detector_in(lsd), .vector_data_in(vd),
    .core_reset_out(cr), .core_freeze_out(fz), .vector_read_out(vr), .vector_addr_out(va),
    .pc_load_out(pl), .pc_value_out(pv), .ram_page_select_out(rp),
    .direct_page_flag_out(dp), .main_clock_select_out(mc), .peripheral_clock_on_out(pc),
    .power_fail_detector_on_out(pfo), .booster_on_out(bo), .stop_release_enable_out(sre),
    .ports_force_input_out(pfi), .ram_write_block_out(rwb), .low_supply_mode_out(lsm));
  rsss_partner u_prt (.core_clk_in(clk),
    .vector_read_in(vr), .vector_addr_in(va), .reset_pin_n_out(pin_n), .vector_data_out(vd));
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1) begin
      fails++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask : check
  task automatic conclude;
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      conclude;
    end
  end
  task automatic wait_boot;
    int n;
    n = 0;
    while (pl !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    check(pl === 1'b1 && boot_len >= STAB + 7, "start-up too short");
    check(pv === 16'h1234, "pc value");
    check(vr === 1'b0 && va === 16'hffff, "vector fetch not ended at high byte");
    check(cr === 1'b0 && rp === 8'h00 && dp === 1'b0 && mc === 1'b1 && pc === 1'b1
      && bo === 1'b0 && pfo === 1'b0, "reset state");
  endtask : wait_boot
  task automatic t_pin;
    u_prt.press(7);
    repeat (4) @(negedge clk);
    check(cr === 1'b0, "short pin low acted");
    u_prt.press(8);
    repeat (4) @(negedge clk);
    check(cr === 1'b1 && rwb === 1'b1, "pin reset missed");
    wait_boot;
  endtask : t_pin
  task automatic t_wdog;
    wd = 1'b1;
    repeat (4) @(negedge clk);
    wd = 1'b0;
    check(cr === 1'b1, "watchdog reset missed");
    wait_boot;
  endtask : t_wdog
  task automatic t_pf(input logic act);
    pfc = 1'b1;
    pfa = act;
    repeat (2) @(negedge clk);
    check(pfo === 1'b1, "detector not armed");
    pfn = 1'b1;
    repeat (12) @(negedge clk);
    check(act ? fz === 1'b1 : cr === 1'b1, "power fail action");
    pfn = 1'b0;
    pfc = 1'b0;
    if (!act) wait_boot;
    else repeat (6) @(negedge clk);
    check(fz === 1'b0, "freeze stuck");
  endtask : t_pf
  task automatic t_lowv;
    lsd = 1'b1;
    repeat (5) @(negedge clk);
    check(lsm === 1'b1 && pfi === 1'b1 && sre === 1'b0 && cr === 1'b1, "low mode");
    check(rwb === 1'b1, "memory writable in low mode");
    lsd = 1'b0;
    repeat (5) @(negedge clk);
    check(lsm === 1'b1, "low mode left without reset");
    u_prt.press(8);
    repeat (4) @(negedge clk);
    check(lsm === 1'b0, "low mode kept after reset");
    wait_boot;
  endtask : t_lowv
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    wait_boot;
    t_pin;
    t_wdog;
    t_pf(1'b0);
    t_pf(1'b1);
    t_lowv;
    conclude;
  end
endmodule : rsss_supervisor_bench
`default_nettype wire
